// *** hdl/pmc_mfr_cmd.sv ***
/*
  Manufacturer command block: peaks, fault delays, addressing, fault log,
  nonvolatile image and calibration words of a two-channel controller.
  Assumes a protocol engine on clk that presents decoded transactions.
*/
`include "pmc_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module pmc_mfr_cmd #(
  parameter int MS_CYCLES = `PMC_MS_NS / `PMC_CLK_NS
) (
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  sys_rst,
  // decoded transactions
  input  wire logic                  cmdValid,
  input  wire logic [6:0]            cmdAddr,
  input  wire pmc_pkg::pmc_kind_type cmdKind,
  input  wire logic [7:0]            cmdCode,
  input  wire logic                  cmdPage,
  input  wire logic [15:0]           cmdWrData,
  input  wire logic [3:0]            cmdBlkIdx,
  output logic                       cmdAck,
  output logic                       cmdRdValid,
  output logic [15:0]                cmdRdData,
  output logic                       cmdNack,
  // measurements
  input  wire logic                  measValid,
  input  wire logic                  measChan,
  input  wire logic [15:0]           measIout,
  input  wire logic [15:0]           measVout,
  input  wire logic [15:0]           measTemp1,
  input  wire logic [15:0]           measVin,
  input  wire logic [15:0]           measTemp2,
  // faults and run control
  input  wire logic [1:0]            faultEvt,
  output logic [1:0]                 runLow,
  output logic [1:0]                 retryGo,
  input  wire logic                  logWrValid,
  input  wire logic [7:0]            logWrData,
  // pins and settings
  input  wire logic [15:0]           pinsAsync,
  output logic [7:0]                 pwmCfg,
  output logic [31:0]                senseTempco,
  output logic [31:0]                tempSlope,
  output logic [31:0]                tempOffset
);
  // ==========================================
  // helpers
  // signed ordering key of a linear-11 value
  function automatic logic signed [47:0] l11Key(input logic [15:0] v);
    logic signed [47:0] m;
    logic [5:0]         sh;
    m  = 48'(signed'(v[10:0]));
    sh = 6'(signed'(v[15:11]) + 16);
    return m <<< sh;
  endfunction : l11Key

  // whole milliseconds, plus one so a free tick never shortens the wait
  function automatic logic [15:0] l11Ms(input logic [15:0] v);
    logic signed [47:0] k;
    k = l11Key(v) >>> 16;
    if (k < 0) return 16'h0001;
    if (k > 48'sh0000_0000_FFFE) return 16'hFFFF;
    return 16'(k) + 16'h0001;
  endfunction : l11Ms

  function automatic pmc_pkg::pmc_nvm_type nvmDefault();
    pmc_pkg::pmc_nvm_type d;
    d.retryDly = {2{`PMC_RST_RETRY_DLY}};
    d.holdDly  = {2{`PMC_RST_HOLD_DLY}};
    d.tempco   = {2{`PMC_RST_TEMPCO}};
    d.slope    = {2{`PMC_RST_SLOPE}};
    d.offset   = {2{`PMC_RST_OFFSET}};
    d.railAddr = {2{`PMC_RST_RAIL_ADDR}};
    d.devAddr  = `PMC_RST_DEV_ADDR;
    d.pwmCfg   = `PMC_RST_PWM_CFG;
    return d;
  endfunction : nvmDefault

  pmc_pkg::pmc_state_type s, n;
  logic [1:0] railHit;
  logic       devHit;
  logic       ch;
  logic       take;
  logic       isSend;
  logic       isWrite;
  logic       isRead;
  logic       msTick;
  logic       resetCmd;
  logic       clearCmd;

  // ==========================================
  // address match
  // device address match
  assign devHit = cmdAddr == s.live.devAddr[6:0];
  // rail address, bit 7 set disables it
  assign railHit[0] = !s.live.railAddr[0][7] && cmdAddr == s.live.railAddr[0][6:0];
  assign railHit[1] = !s.live.railAddr[1][7] && cmdAddr == s.live.railAddr[1][6:0];
  assign ch      = railHit[1] ? 1'b1 : railHit[0] ? 1'b0 : cmdPage;
  assign cmdAck  = cmdValid && (devHit || railHit != 2'b00);
  assign take    = cmdAck;
  assign isSend  = take && cmdKind == pmc_pkg::PMC_SEND;
  assign isWrite = take && cmdKind == pmc_pkg::PMC_WRITE;
  assign isRead  = take && cmdKind == pmc_pkg::PMC_READ;
  assign msTick  = s.msCnt == 15'(MS_CYCLES - 1);
  assign resetCmd = isSend && cmdCode == `PMC_CMD_SOFT_RESET;
  assign clearCmd = isSend && cmdCode == `PMC_CMD_PK_CLEAR;

  // ==========================================
  // next state
  always_comb begin
    n = s;
    n.retryGo = 2'b00;
    n.rdValid = 1'b0;
    n.nack    = 1'b0;
    n.pinS1   = pinsAsync;
    n.pinS2   = s.pinS1;
    n.msCnt   = msTick ? 15'h0000 : s.msCnt + 15'h0001;
    for (int c = 0; c < 2; c++) begin
      if (msTick && s.retryCnt[c] != 16'h0000) n.retryCnt[c] = s.retryCnt[c] - 16'h0001;
      if (msTick && s.holdCnt[c] != 16'h0000) n.holdCnt[c] = s.holdCnt[c] - 16'h0001;
      // retry only once both waits ran out
      if (s.retryPend[c] && s.retryCnt[c] == 16'h0000 && s.holdCnt[c] == 16'h0000) begin
        n.retryPend[c] = 1'b0;
        n.runLow[c]    = 1'b0;
        n.retryGo[c]   = 1'b1;
      end
      if (faultEvt[c]) begin
        // fault beats a same-cycle expiry
        n.retryGo[c]   = 1'b0;
        n.runLow[c]    = 1'b1;
        n.retryPend[c] = 1'b1;
        n.holdCnt[c]   = l11Ms(s.live.holdDly[c]);
        n.retryCnt[c]  = l11Ms(s.live.retryDly[c]);
      end
    end
    // compare in each register's own format
    if (measValid) begin
      if (s.pkEmpty[measChan] || l11Key(measIout) > l11Key(s.pkIout[measChan])) begin
        n.pkIout[measChan] = measIout;
        n.pkEmpty[measChan] = 1'b0;
      end
      if (s.pkEmpty[2 + measChan] || measVout > s.pkVout[measChan]) begin
        n.pkVout[measChan] = measVout;
        n.pkEmpty[2 + measChan] = 1'b0;
      end
      if (s.pkEmpty[4 + measChan] || l11Key(measTemp1) > l11Key(s.pkTemp1[measChan])) begin
        n.pkTemp1[measChan] = measTemp1;
        n.pkEmpty[4 + measChan] = 1'b0;
      end
      if (s.pkEmpty[6] || l11Key(measVin) > l11Key(s.pkVin)) begin
        n.pkVin = measVin;
        n.pkEmpty[6] = 1'b0;
      end
      if (s.pkEmpty[7] || l11Key(measTemp2) > l11Key(s.pkTemp2)) begin
        n.pkTemp2 = measTemp2;
        n.pkEmpty[7] = 1'b0;
      end
    end
    // working log wraps, keeping the newest entries
    if (logWrValid) begin
      n.opLog[s.logWp] = logWrData;
      n.logWp = s.logWp + 4'h1;
    end
    if (isSend) begin
      case (cmdCode)
        // empty peaks reload on next reading
        `PMC_CMD_PK_CLEAR: begin
          n.pkEmpty = 8'hFF;
          n.pkIout = '0;
          n.pkVout = '0;
          n.pkTemp1 = '0;
          n.pkVin = 16'h0000;
          n.pkTemp2 = 16'h0000;
        end
        `PMC_CMD_LOG_SAVE: begin
          n.eeLog = s.opLog;
          n.eeLogValid = 1'b1;
        end
        `PMC_CMD_LOG_ERASE: begin
          n.eeLog = '0;
          n.eeLogValid = 1'b0;
        end
        `PMC_CMD_NVM_CMP: n.mismatch = s.live != s.ee;
        `PMC_CMD_STORE_ALL: n.ee = s.live;
        `PMC_CMD_RESTORE_ALL: n.live = s.ee;
        `PMC_CMD_SOFT_RESET: begin
          n.live = s.ee;
          n.pkEmpty = 8'hFF;
          n.pkIout = '0;
          n.pkVout = '0;
          n.pkTemp1 = '0;
          n.pkVin = 16'h0000;
          n.pkTemp2 = 16'h0000;
          n.opLog = '0;
          n.logWp = 4'h0;
          n.mismatch = 1'b0;
          n.retryCnt = '0;
          n.holdCnt = '0;
          n.retryPend = 2'b00;
          n.runLow = 2'b00;
          n.retryGo = 2'b00;
        end
        default: n.nack = 1'b1;
      endcase
    end
    if (isWrite) begin
      case (cmdCode)
        `PMC_CMD_RETRY_DLY: n.live.retryDly[ch] = cmdWrData;
        `PMC_CMD_HOLD_DLY: n.live.holdDly[ch] = cmdWrData;
        `PMC_CMD_DEV_ADDR: n.live.devAddr = {1'b0, cmdWrData[6:0]};
        `PMC_CMD_PWM_CFG: n.live.pwmCfg = cmdWrData[7:0];
        `PMC_CMD_TEMPCO: n.live.tempco[ch] = cmdWrData;
        `PMC_CMD_SLOPE: n.live.slope[ch] = cmdWrData;
        `PMC_CMD_OFFSET: n.live.offset[ch] = cmdWrData;
        `PMC_CMD_RAIL_ADDR: n.live.railAddr[ch] = cmdWrData[7:0];
        default: n.nack = 1'b1;
      endcase
    end
    if (isRead) begin
      n.rdValid = 1'b1;
      case (cmdCode)
        `PMC_CMD_PK_IOUT: n.rdData = s.pkIout[ch];
        `PMC_CMD_PK_VOUT: n.rdData = s.pkVout[ch];
        `PMC_CMD_PK_VIN: n.rdData = s.pkVin;
        `PMC_CMD_PK_TEMP1: n.rdData = s.pkTemp1[ch];
        `PMC_CMD_PK_TEMP2: n.rdData = s.pkTemp2;
        `PMC_CMD_RETRY_DLY: n.rdData = s.live.retryDly[ch];
        `PMC_CMD_HOLD_DLY: n.rdData = s.live.holdDly[ch];
        `PMC_CMD_PIN_STATE: n.rdData = s.pinS2;
        `PMC_CMD_DEV_ADDR: n.rdData = {8'h00, s.live.devAddr};
        `PMC_CMD_LOG_BLOCK: n.rdData = {8'h00, s.eeLog[cmdBlkIdx]};
        `PMC_CMD_STATUS: begin
          n.rdData = 16'h0000;
          n.rdData[`PMC_ST_MISMATCH] = s.mismatch;
          n.rdData[`PMC_ST_LOG_VALID] = s.eeLogValid;
          n.rdData[`PMC_ST_RETRY_PEND] = |s.retryPend;
        end
        `PMC_CMD_PWM_CFG: n.rdData = {8'h00, s.live.pwmCfg};
        `PMC_CMD_TEMPCO: n.rdData = s.live.tempco[ch];
        `PMC_CMD_SLOPE: n.rdData = s.live.slope[ch];
        `PMC_CMD_OFFSET: n.rdData = s.live.offset[ch];
        `PMC_CMD_RAIL_ADDR: n.rdData = {8'h00, s.live.railAddr[ch]};
        default: begin
          n.rdData  = 16'h0000;
          n.rdValid = 1'b0;
          n.nack    = 1'b1;
        end
      endcase
    end
  end

  // ==========================================
  // state register
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s <= '0;
      s.live <= nvmDefault();
      s.ee <= nvmDefault();
      s.pkEmpty <= 8'hFF;
    end else begin
      s <= n;
    end
  end

  assign cmdRdValid  = s.rdValid;
  assign cmdRdData   = s.rdData;
  assign cmdNack     = s.nack;
  assign runLow      = s.runLow;
  assign retryGo     = s.retryGo;
  assign pwmCfg      = s.live.pwmCfg;
  assign senseTempco = s.live.tempco;
  assign tempSlope   = s.live.slope;
  assign tempOffset  = s.live.offset;

  // ==========================================
  // checks
  logic signed [47:0] vinPkKey;
  logic [15:0]        retryLoad0;
  logic [7:0]         logByte;
  assign vinPkKey   = l11Key(s.pkVin);
  assign retryLoad0 = l11Ms(s.live.retryDly[0]);
  assign logByte    = s.eeLog[cmdBlkIdx];

  sequence seqClear;
    clearCmd;
  endsequence
  sequence seqLogRead;
    isRead && cmdCode == `PMC_CMD_LOG_BLOCK;
  endsequence

  AST_PEAK_CLEAR: assert property (@(posedge clk) disable iff (sys_rst)
    seqClear |=> s.pkEmpty == 8'hFF ##1 ($past(measValid) || s.pkEmpty == 8'hFF))
    else $error("peaks not cleared");
  AST_PEAK_HOLD: assert property (@(posedge clk) disable iff (sys_rst)
    !s.pkEmpty[6] && !clearCmd && !resetCmd |=> vinPkKey >= $past(vinPkKey))
    else $error("input voltage peak fell");
  AST_PEAK_TRACK: assert property (@(posedge clk) disable iff (sys_rst)
    measValid && !clearCmd && !resetCmd && l11Key(measVin) > vinPkKey
    |=> s.pkVin == $past(measVin))
    else $error("higher reading not taken");
  AST_RETRY_LOAD: assert property (@(posedge clk) disable iff (sys_rst)
    faultEvt[0] && !resetCmd |=> s.retryCnt[0] == $past(retryLoad0) && s.runLow[0])
    else $error("retry delay not loaded");
  AST_FAULT_WINS: assert property (@(posedge clk) disable iff (sys_rst)
    faultEvt[0] && !resetCmd |=> !retryGo[0] && s.retryPend[0])
    else $error("retry granted on a fresh fault");
  AST_RETRY_WAIT: assert property (@(posedge clk) disable iff (sys_rst)
    retryGo[0] |-> $past(s.retryCnt[0]) == 16'h0000 && $past(s.holdCnt[0]) == 16'h0000)
    else $error("retry before delay expired");
  AST_RUN_HOLD: assert property (@(posedge clk) disable iff (sys_rst)
    s.runLow[0] && s.holdCnt[0] != 16'h0000 && !resetCmd |=> s.runLow[0])
    else $error("run released early");
  AST_DEV_ADDR: assert property (@(posedge clk) disable iff (sys_rst)
    cmdValid && cmdAddr == s.live.devAddr[6:0] |-> cmdAck)
    else $error("own address ignored");
  AST_RAIL_ADDR: assert property (@(posedge clk) disable iff (sys_rst)
    cmdValid && !s.live.railAddr[1][7] && cmdAddr == s.live.railAddr[1][6:0]
    |-> cmdAck && ch)
    else $error("rail address ignored");
  AST_LOG_SAVE: assert property (@(posedge clk) disable iff (sys_rst)
    isSend && cmdCode == `PMC_CMD_LOG_SAVE |=> s.eeLog == $past(s.opLog) && s.eeLogValid)
    else $error("log not saved");
  AST_LOG_ERASE: assert property (@(posedge clk) disable iff (sys_rst)
    isSend && cmdCode == `PMC_CMD_LOG_ERASE |=> !s.eeLogValid && s.eeLog == '0)
    else $error("log not erased");
  AST_LOG_READ: assert property (@(posedge clk) disable iff (sys_rst)
    seqLogRead |=> cmdRdValid && cmdRdData == {8'h00, $past(logByte)})
    else $error("wrong log byte");
  AST_SOFT_RESET: assert property (@(posedge clk) disable iff (sys_rst)
    resetCmd |=> s.live == $past(s.ee) && s.pkEmpty == 8'hFF && runLow == 2'b00)
    else $error("full reset incomplete");
endmodule : pmc_mfr_cmd
`default_nettype wire

// *** hdl/pmc_regs.svh ***
/*
  Command codes, reset values and timing counts of the manufacturer command block.
  Assumes a 20 MHz clk and the PMBus linear formats for word values.
*/
`ifndef PMC_REGS_SVH
`define PMC_REGS_SVH
// ==========================================
// command codes
`define PMC_CMD_STORE_ALL    8'h15
`define PMC_CMD_RESTORE_ALL  8'h16
`define PMC_CMD_PK_IOUT      8'hD7
`define PMC_CMD_RETRY_DLY    8'hDB
`define PMC_CMD_HOLD_DLY     8'hDC
`define PMC_CMD_PK_VOUT      8'hDD
`define PMC_CMD_PK_VIN       8'hDE
`define PMC_CMD_PK_TEMP1     8'hDF
`define PMC_CMD_PK_CLEAR     8'hE3
`define PMC_CMD_PIN_STATE    8'hE5
`define PMC_CMD_DEV_ADDR     8'hE6
`define PMC_CMD_LOG_SAVE     8'hEA
`define PMC_CMD_LOG_ERASE    8'hEC
`define PMC_CMD_LOG_BLOCK    8'hEE
`define PMC_CMD_STATUS       8'hEF
`define PMC_CMD_NVM_CMP      8'hF0
`define PMC_CMD_PK_TEMP2     8'hF4
`define PMC_CMD_PWM_CFG      8'hF5
`define PMC_CMD_TEMPCO       8'hF6
`define PMC_CMD_SLOPE        8'hF8
`define PMC_CMD_OFFSET       8'hF9
`define PMC_CMD_RAIL_ADDR    8'hFA
`define PMC_CMD_SOFT_RESET   8'hFD
// ==========================================
// reset values
`define PMC_RST_RETRY_DLY    16'hFABC
`define PMC_RST_HOLD_DLY     16'hFBE8
`define PMC_RST_DEV_ADDR     8'h4F
`define PMC_RST_PWM_CFG      8'h14
`define PMC_RST_TEMPCO       16'h0F3C
`define PMC_RST_SLOPE        16'h4000
`define PMC_RST_OFFSET       16'h8000
`define PMC_RST_RAIL_ADDR    8'h80
// ==========================================
// status bits and timing
`define PMC_ST_MISMATCH      0
`define PMC_ST_LOG_VALID     1
`define PMC_ST_RETRY_PEND    2
`define PMC_MS_NS            1000000
`define PMC_CLK_NS           50
`endif

// *** hdl/pmc_pkg.sv ***
/*
  Types of the manufacturer command block.
  Assumes pmc_regs.svh for the numeric values.
*/
package pmc_pkg;
  typedef enum logic [1:0] {
    PMC_SEND  = 2'b00,
    PMC_WRITE = 2'b01,
    PMC_READ  = 2'b10
  } pmc_kind_type;

  // nonvolatile image, held live and as the eeprom copy
  typedef struct packed {
    logic [1:0][15:0] retryDly;
    logic [1:0][15:0] holdDly;
    logic [1:0][15:0] tempco;
    logic [1:0][15:0] slope;
    logic [1:0][15:0] offset;
    logic [1:0][7:0]  railAddr;
    logic [7:0]       devAddr;
    logic [7:0]       pwmCfg;
  } pmc_nvm_type;

  typedef struct packed {
    pmc_nvm_type        live;
    pmc_nvm_type        ee;
    logic [1:0][15:0]   pkIout;
    logic [1:0][15:0]   pkVout;
    logic [1:0][15:0]   pkTemp1;
    logic [15:0]        pkVin;
    logic [15:0]        pkTemp2;
    logic [7:0]         pkEmpty;
    logic [15:0][7:0]   opLog;
    logic [15:0][7:0]   eeLog;
    logic [3:0]         logWp;
    logic               eeLogValid;
    logic               mismatch;
    logic [14:0]        msCnt;
    logic [1:0][15:0]   retryCnt;
    logic [1:0][15:0]   holdCnt;
    logic [1:0]         retryPend;
    logic [1:0]         runLow;
    logic [1:0]         retryGo;
    logic [15:0]        pinS1;
    logic [15:0]        pinS2;
    logic [15:0]        rdData;
    logic               rdValid;
    logic               nack;
  } pmc_state_type;
endpackage : pmc_pkg

// *** bench/pmc_host_model.sv ***
/*
  Host model: issues decoded bus transactions to the manufacturer command block.
  Assumes the block answers on the same clk edge that takes a request.
*/
`timescale 1ns/1ps
`default_nettype none
module pmc_host_model (
  // clock
  input  wire logic                  clk,
  // request
  output logic                       cmdValid,
  output logic [6:0]                 cmdAddr,
  output var pmc_pkg::pmc_kind_type  cmdKind,
  output logic [7:0]                 cmdCode,
  output logic                       cmdPage,
  output logic [15:0]                cmdWrData,
  output logic [3:0]                 cmdBlkIdx,
  // answer
  input  wire logic                  cmdAck,
  input  wire logic                  cmdRdValid,
  input  wire logic [15:0]           cmdRdData,
  input  wire logic                  cmdNack
);
  logic        gotAck;
  logic        gotRd;
  logic        gotNack;
  logic [15:0] rdWord;

  initial begin
    cmdValid  = 1'b0;
    cmdAddr   = 7'h00;
    cmdKind   = pmc_pkg::PMC_SEND;
    cmdCode   = 8'h00;
    cmdPage   = 1'b0;
    cmdWrData = 16'h0000;
    cmdBlkIdx = 4'h0;
  end

  // ==========================================
  // one transaction, answer taken one edge later
  task automatic xfer(input logic [6:0] a, input pmc_pkg::pmc_kind_type k,
                      input logic [7:0] c, input logic p, input logic [15:0] d,
                      input logic [3:0] i);
    @(posedge clk);
    #1;
    cmdValid  = 1'b1;
    cmdAddr   = a;
    cmdKind   = k;
    cmdCode   = c;
    cmdPage   = p;
    cmdWrData = d;
    cmdBlkIdx = i;
    #1;
    gotAck = cmdAck;
    @(posedge clk);
    #1;
    gotRd   = cmdRdValid;
    gotNack = cmdNack;
    rdWord  = cmdRdData;
    // released lines other than cmdKind must not keep the old value
    cmdValid  = 1'b0;
    cmdAddr   = ~a;
    cmdCode   = ~c;
    cmdPage   = ~p;
    cmdWrData = ~d;
    cmdBlkIdx = ~i;
  endtask : xfer
endmodule : pmc_host_model
`default_nettype wire

// *** bench/test_pmbus_mfr_command_block.sv ***
/*
  Self-checking bench of the manufacturer command block.
  Assumes pmc_pkg and the host model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module test_pmbus_mfr_command_block;
  // ==========================================
  // signals
  localparam int MsCyc = 4;
  localparam pmc_pkg::pmc_kind_type Rd = pmc_pkg::PMC_READ;
  localparam pmc_pkg::pmc_kind_type Wr = pmc_pkg::PMC_WRITE;
  localparam pmc_pkg::pmc_kind_type Sd = pmc_pkg::PMC_SEND;
  typedef struct packed {
    pmc_pkg::pmc_kind_type kind;
    logic [7:0]            code;
    logic                  page;
    logic [15:0]           data;
    logic                  nack;
  } pmc_row_type;
  logic clk, sys_rst, cmdValid, cmdPage, cmdAck, cmdRdValid, cmdNack;
  logic [6:0] cmdAddr;
  logic [6:0] devA;
  pmc_pkg::pmc_kind_type cmdKind;
  logic [7:0] cmdCode, logWrData, pwmCfg;
  logic [15:0] cmdWrData, cmdRdData, measIout, measVout, measTemp1, measVin, measTemp2;
  logic [15:0] pinsAsync;
  logic [3:0] cmdBlkIdx;
  logic measValid, measChan, logWrValid;
  logic [1:0] faultEvt, runLow, retryGo;
  logic [31:0] senseTempco, tempSlope, tempOffset;
  int miscompares, checks, n;
  pmc_row_type rows [21];

  pmc_mfr_cmd #(.MS_CYCLES(MsCyc)) pmc_mfr_cmd_inst (
    .clk(clk), .sys_rst(sys_rst), .cmdValid(cmdValid), .cmdAddr(cmdAddr),
    .cmdKind(cmdKind), .cmdCode(cmdCode), .cmdPage(cmdPage), .cmdWrData(cmdWrData),
    .cmdBlkIdx(cmdBlkIdx), .cmdAck(cmdAck), .cmdRdValid(cmdRdValid),
    .cmdRdData(cmdRdData), .cmdNack(cmdNack), .measValid(measValid),
    .measChan(measChan), .measIout(measIout), .measVout(measVout),
    .measTemp1(measTemp1), .measVin(measVin), .measTemp2(measTemp2),
    .faultEvt(faultEvt), .runLow(runLow), .retryGo(retryGo), .logWrValid(logWrValid),
    .logWrData(logWrData), .pinsAsync(pinsAsync), .pwmCfg(pwmCfg),
    .senseTempco(senseTempco), .tempSlope(tempSlope), .tempOffset(tempOffset));

  pmc_host_model pmc_host_model_inst (
    .clk(clk), .cmdValid(cmdValid), .cmdAddr(cmdAddr), .cmdKind(cmdKind),
    .cmdCode(cmdCode), .cmdPage(cmdPage), .cmdWrData(cmdWrData),
    .cmdBlkIdx(cmdBlkIdx), .cmdAck(cmdAck), .cmdRdValid(cmdRdValid),
    .cmdRdData(cmdRdData), .cmdNack(cmdNack));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ==========================================
  // compare and bus tasks
  task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : check_word
  task automatic check_flag(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : check_flag
  task automatic op(input pmc_pkg::pmc_kind_type k, input logic [7:0] c, input logic p,
                    input logic [15:0] d);
    pmc_host_model_inst.xfer(devA, k, c, p, d, 4'h0);
  endtask : op
  task automatic rd_chk(input logic [7:0] c, input logic p, input logic [15:0] e);
    op(Rd, c, p, 16'h0000);
    check_word(pmc_host_model_inst.rdWord, e);
  endtask : rd_chk
  task automatic st_bit(input int b, input logic e);
    op(Rd, 8'hEF, 1'b0, 16'h0000);
    check_flag(pmc_host_model_inst.rdWord[b], e);
  endtask : st_bit
  task automatic meas(input logic ch, input logic [15:0] io, vo, t1, vi, t2);
    @(posedge clk);
    #1;
    measValid = 1'b1;
    measChan  = ch;
    measIout  = io;
    measVout  = vo;
    measTemp1 = t1;
    measVin   = vi;
    measTemp2 = t2;
    @(posedge clk);
    #1;
    measValid = 1'b0;
  endtask : meas
  task automatic fault_run(input logic [15:0] rtr, hld, input int lo, hi);
    op(Wr, 8'hDB, 1'b0, rtr);
    op(Wr, 8'hDC, 1'b0, hld);
    @(posedge clk);
    #1;
    faultEvt = 2'b01;
    @(posedge clk);
    #1;
    faultEvt = 2'b00;
    check_flag(runLow[0], 1'b1);
    n = 1;
    while (retryGo[0] !== 1'b1 && n < 200) begin
      @(posedge clk);
      #1;
      n++;
    end
    check_flag(n >= lo && n <= hi, 1'b1);
    check_flag(runLow[0], 1'b0);
    check_flag(runLow[1] | retryGo[1], 1'b0);
  endtask : fault_run
  task automatic give_verdict();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : give_verdict

  // ==========================================
  // watchdog: over twenty times the expected run
  initial begin
    #(5000 * 50);
    miscompares++;
    give_verdict();
  end

  // ==========================================
  // main sequence
  initial begin
    rows = '{'{Rd, 8'hDB, 1'b0, 16'hFABC, 1'b0}, '{Rd, 8'hDB, 1'b1, 16'hFABC, 1'b0},
             '{Rd, 8'hDC, 1'b1, 16'hFBE8, 1'b0}, '{Rd, 8'hE6, 1'b0, 16'h004F, 1'b0},
             '{Rd, 8'hF5, 1'b0, 16'h0014, 1'b0}, '{Rd, 8'hF6, 1'b1, 16'h0F3C, 1'b0},
             '{Rd, 8'hF8, 1'b0, 16'h4000, 1'b0}, '{Rd, 8'hF9, 1'b1, 16'h8000, 1'b0},
             '{Rd, 8'hFA, 1'b0, 16'h0080, 1'b0}, '{Rd, 8'hD7, 1'b0, 16'h0000, 1'b0},
             '{Wr, 8'hD7, 1'b0, 16'h0001, 1'b1}, '{Rd, 8'hE3, 1'b0, 16'h0000, 1'b1},
             '{Rd, 8'hC0, 1'b0, 16'h0000, 1'b1}, '{Wr, 8'hEF, 1'b0, 16'h0001, 1'b1},
             '{Wr, 8'hF6, 1'b1, 16'h1234, 1'b0}, '{Rd, 8'hF6, 1'b1, 16'h1234, 1'b0},
             '{Rd, 8'hF6, 1'b0, 16'h0F3C, 1'b0}, '{Wr, 8'hF5, 1'b0, 16'h0055, 1'b0},
             '{Rd, 8'hF5, 1'b0, 16'h0055, 1'b0}, '{Wr, 8'hF8, 1'b0, 16'h2000, 1'b0},
             '{Rd, 8'hF8, 1'b0, 16'h2000, 1'b0}};
    {measValid, measChan, logWrValid, faultEvt, logWrData} = '0;
    {measIout, measVout, measTemp1, measVin, measTemp2} = '0;
    pinsAsync = 16'hA5C3;
    devA = 7'h4F;
    sys_rst = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    foreach (rows[i]) begin
      op(rows[i].kind, rows[i].code, rows[i].page, rows[i].data);
      check_flag(pmc_host_model_inst.gotAck, 1'b1);
      check_flag(pmc_host_model_inst.gotNack, rows[i].nack);
      check_flag(pmc_host_model_inst.gotRd, rows[i].kind == Rd && !rows[i].nack);
      if (rows[i].kind == Rd && !rows[i].nack) begin
        check_word(pmc_host_model_inst.rdWord, rows[i].data);
      end
    end
    check_word(senseTempco[31:16], 16'h1234);
    check_word(tempSlope[15:0], 16'h2000);
    check_word(tempOffset[31:16], 16'h8000);
    check_word({8'h00, pwmCfg}, 16'h0055);
    $display("test table finished");
    rd_chk(8'hE5, 1'b0, 16'hA5C3);
    pinsAsync = 16'h5A3C;
    repeat (3) @(posedge clk);
    rd_chk(8'hE5, 1'b0, 16'h5A3C);
    $display("test pins finished");
    meas(1'b0, 16'h0010, 16'h7000, 16'h0005, 16'h0020, 16'h0007);
    meas(1'b0, 16'h07FF, 16'h9000, 16'h0003, 16'h0010, 16'h0002);
    meas(1'b1, 16'h0009, 16'h0100, 16'h0001, 16'h0001, 16'h0001);
    rd_chk(8'hD7, 1'b0, 16'h0010);
    rd_chk(8'hDD, 1'b0, 16'h9000);
    rd_chk(8'hDE, 1'b0, 16'h0020);
    rd_chk(8'hDF, 1'b0, 16'h0005);
    rd_chk(8'hF4, 1'b0, 16'h0007);
    rd_chk(8'hD7, 1'b1, 16'h0009);
    op(Sd, 8'hE3, 1'b0, 16'h0000);
    rd_chk(8'hD7, 1'b0, 16'h0000);
    meas(1'b0, 16'h0003, 16'h0001, 16'h0001, 16'h0001, 16'h0001);
    rd_chk(8'hD7, 1'b0, 16'h0003);
    $display("test peaks finished");
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      #1;
      logWrValid = 1'b1;
      logWrData  = {4'hA + 4'(i), 4'h1 + 4'(i)};
    end
    @(posedge clk);
    #1;
    logWrValid = 1'b0;
    op(Sd, 8'hEA, 1'b0, 16'h0000);
    st_bit(1, 1'b1);
    for (int i = 0; i < 3; i++) begin
      pmc_host_model_inst.xfer(devA, Rd, 8'hEE, 1'b0, 16'h0000, 4'(i));
      check_word(pmc_host_model_inst.rdWord, {8'h00, 4'hA + 4'(i), 4'h1 + 4'(i)});
    end
    op(Sd, 8'hEC, 1'b0, 16'h0000);
    st_bit(1, 1'b0);
    $display("test fault log finished");
    op(Sd, 8'hF0, 1'b0, 16'h0000);
    st_bit(0, 1'b1);
    op(Sd, 8'h15, 1'b0, 16'h0000);
    op(Sd, 8'hF0, 1'b0, 16'h0000);
    st_bit(0, 1'b0);
    op(Wr, 8'hF5, 1'b0, 16'h0077);
    op(Sd, 8'h16, 1'b0, 16'h0000);
    @(posedge clk);
    #1;
    check_word({8'h00, pwmCfg}, 16'h0055);
    op(Wr, 8'hF5, 1'b0, 16'h0066);
    op(Sd, 8'hFD, 1'b0, 16'h0000);
    @(posedge clk);
    #1;
    check_word({8'h00, pwmCfg}, 16'h0055);
    rd_chk(8'hD7, 1'b0, 16'h0000);
    $display("test memory image finished");
    fault_run(16'h0002, 16'h0005, 5 * MsCyc, 7 * MsCyc + 2);
    fault_run(16'h0003, 16'h0001, 3 * MsCyc, 5 * MsCyc + 2);
    $display("test fault delays finished");
    op(Wr, 8'hE6, 1'b0, 16'h0023);
    devA = 7'h23;
    rd_chk(8'hE6, 1'b0, 16'h0023);
    pmc_host_model_inst.xfer(7'h4F, Rd, 8'hE6, 1'b0, 16'h0000, 4'h0);
    check_flag(pmc_host_model_inst.gotAck | pmc_host_model_inst.gotRd, 1'b0);
    op(Wr, 8'hFA, 1'b1, 16'h0030);
    pmc_host_model_inst.xfer(7'h30, Rd, 8'hF6, 1'b0, 16'h0000, 4'h0);
    check_word(pmc_host_model_inst.rdWord, 16'h1234);
    $display("test addressing finished");
    sys_rst = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    devA = 7'h4F;
    check_word({8'h00, pwmCfg}, 16'h0014);
    rd_chk(8'hE6, 1'b0, 16'h004F);
    $display("test second reset finished");
    give_verdict();
  end
endmodule : test_pmbus_mfr_command_block
`default_nettype wire
